// ### core/imc_device.sv
`timescale 1ns/100ps
`default_nettype none
module imc_device
  import imc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  imc_link_if.dev link,
  input wire logic [3:0] selftest_fail_bits,
  input wire logic flash_fail,
  input wire logic save_fail,
  output logic sw_reset,
  output logic [FILT_SEL_W-1:0] filter_sel,
  output logic filter_apply,
  output logic [NUM_OPS-1:0] op_busy
);
  logic [1:0] rx_idx_reg;
  logic [7:0] rx_addr_reg;
  logic [7:0] rx_data_reg;
  logic page_reg;
  logic frame_ok;
  logic is_wr;
  logic wr_p1;
  logic rd_req;
  logic [NUM_OPS-1:0] op_start;
  logic [NUM_OPS-1:0] op_done;
  logic [3:0] st_fail_reg;
  logic flash_fail_reg;
  logic save_fail_reg;
  logic [31:0] tx_buf_reg;
  logic [2:0] tx_cnt_reg;
  logic [15:0] rd_word;

  // byte position within a three-byte frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_idx_reg <= 2'd0;
    end else if (link.h2d_valid) begin
      rx_idx_reg <= (rx_idx_reg == 2'd2) ? 2'd0 : rx_idx_reg + 2'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_addr_reg <= 8'h00;
      rx_data_reg <= 8'h00;
    end else if (link.h2d_valid && rx_idx_reg == 2'd0) begin
      rx_addr_reg <= link.h2d_byte;
    end else if (link.h2d_valid && rx_idx_reg == 2'd1) begin
      rx_data_reg <= link.h2d_byte;
    end
  end

  // a frame counts only when its third byte is the terminator
  assign frame_ok = link.h2d_valid && rx_idx_reg == 2'd2 && link.h2d_byte == TERM_BYTE;
  assign is_wr = frame_ok && rx_addr_reg[WR_FLAG_BIT];
  assign wr_p1 = is_wr && page_reg;
  assign rd_req = frame_ok && !rx_addr_reg[WR_FLAG_BIT] && rx_data_reg == READ_PAD;

  // page select, held until rewritten or soft reset
  always_ff @(posedge clk) begin
    if (!rst_n || sw_reset) begin
      page_reg <= PAGE_RESET;
    end else if (is_wr && rx_addr_reg == ADDR_PAGE) begin
      page_reg <= rx_data_reg[0];
    end
  end

  // command decode, page 1 only
  always_comb begin
    op_start = '0;
    op_start[OP_SELFTEST] = wr_p1 && rx_addr_reg == WADDR_MISC_HI
      && rx_data_reg == CMD_SELFTEST;
    op_start[OP_FLASHTEST] = wr_p1 && rx_addr_reg == WADDR_MISC_HI
      && rx_data_reg == CMD_FLASHTEST;
    op_start[OP_BACKUP] = wr_p1 && rx_addr_reg == WADDR_GLOB_LO
      && rx_data_reg == CMD_BACKUP;
    op_start[OP_INITBACKUP] = wr_p1 && rx_addr_reg == WADDR_GLOB_LO
      && rx_data_reg == CMD_INITBACKUP;
    op_start[OP_FILTER] = wr_p1 && rx_addr_reg == WADDR_FILT_LO
      && !op_busy[OP_FILTER];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_reset <= 1'b0;
    end else begin
      sw_reset <= wr_p1 && rx_addr_reg == WADDR_GLOB_LO && rx_data_reg == CMD_SWRESET;
    end
  end

  // filter selection, avg_32_taps among the codes
  always_ff @(posedge clk) begin
    if (!rst_n || sw_reset) begin
      filter_sel <= FILT_SEL_RESET;
      filter_apply <= 1'b0;
    end else begin
      filter_apply <= op_start[OP_FILTER];
      if (op_start[OP_FILTER]) begin
        filter_sel <= rx_data_reg[FILT_SEL_W-1:0];
      end
    end
  end

  // one timer per maintenance operation; busy clears itself
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OPS; gi++) begin : g_op
      imc_op_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .clear(sw_reset),
        .start(op_start[gi]),
        .busy(op_busy[gi]),
        .done(op_done[gi])
      );
    end
  endgenerate

  // outcome bits captured when the operation ends
  always_ff @(posedge clk) begin
    if (!rst_n || sw_reset) begin
      st_fail_reg <= 4'h0;
      flash_fail_reg <= 1'b0;
      save_fail_reg <= 1'b0;
    end else begin
      if (op_done[OP_SELFTEST]) begin
        st_fail_reg <= selftest_fail_bits;
      end
      if (op_done[OP_FLASHTEST]) begin
        flash_fail_reg <= flash_fail;
      end
      if (op_done[OP_BACKUP] || op_done[OP_INITBACKUP]) begin
        save_fail_reg <= save_fail;
      end
    end
  end

  // read mux; address space depends on the page
  always_comb begin
    rd_word = 16'h0000;
    if (page_reg) begin
      case (rx_addr_reg[6:0])
        REG_MISC: begin
          rd_word[MISC_SELFTEST_BIT] = op_busy[OP_SELFTEST];
          rd_word[MISC_FLASHTEST_BIT] = op_busy[OP_FLASHTEST];
        end
        REG_GLOB: begin
          rd_word[GLOB_BACKUP_BIT] = op_busy[OP_BACKUP];
          rd_word[GLOB_INITBACKUP_BIT] = op_busy[OP_INITBACKUP];
        end
        REG_FILT: begin
          rd_word[FILT_SEL_W-1:0] = filter_sel;
          rd_word[FILT_BUSY_BIT] = op_busy[OP_FILTER];
        end
        default: begin
          rd_word = 16'h0000;
        end
      endcase
    end else begin
      case (rx_addr_reg[6:0])
        REG_DIAG: begin
          rd_word[DIAG_ST_LSB+3:DIAG_ST_LSB] = st_fail_reg;
          rd_word[DIAG_FLASH_BIT] = flash_fail_reg;
          rd_word[DIAG_SAVE_BIT] = save_fail_reg;
        end
        default: begin
          rd_word = 16'h0000;
        end
      endcase
    end
  end

  // reply shifter; a read arriving mid-reply is dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_buf_reg <= 32'h00000000;
      tx_cnt_reg <= 3'd0;
    end else if (rd_req && tx_cnt_reg == 3'd0) begin
      tx_buf_reg <= {rx_addr_reg, rd_word, TERM_BYTE};
      tx_cnt_reg <= 3'd4;
    end else if (tx_cnt_reg != 3'd0) begin
      tx_buf_reg <= {tx_buf_reg[23:0], 8'h00};
      tx_cnt_reg <= tx_cnt_reg - 3'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.d2h_valid <= 1'b0;
      link.d2h_byte <= 8'h00;
    end else begin
      link.d2h_valid <= tx_cnt_reg != 3'd0;
      link.d2h_byte <= (tx_cnt_reg != 3'd0) ? tx_buf_reg[31:24] : 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### core/imc_host.sv
`timescale 1ns/100ps
`default_nettype none
module imc_host
  import imc_pkg::*;
#(
  parameter int unsigned RESET_WAIT = RESET_WAIT_CYC
)(
  input wire logic clk,
  input wire logic rst_n,
  imc_link_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_addr,
  output logic [15:0] rsp_word,
  output logic reset_wait
);
  imc_host_state_t state_reg;
  logic [23:0] frame_reg;
  logic [1:0] cnt_reg;
  logic write_reg;
  logic is_reset_reg;
  logic page_reg;
  logic [31:0] wait_reg;
  logic [23:0] rsp_sh_reg;

  assign cmd_ready = state_reg == IMC_IDLE;
  assign reset_wait = state_reg == IMC_HOLD;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= IMC_IDLE;
      frame_reg <= 24'h000000;
      cnt_reg <= 2'd0;
      write_reg <= 1'b0;
      is_reset_reg <= 1'b0;
      wait_reg <= 32'h00000000;
    end else begin
      case (state_reg)
        IMC_IDLE: begin
          if (cmd_valid) begin
            write_reg <= cmd_write;
            frame_reg <= cmd_write ? {1'b1, cmd_addr[6:0], cmd_data, TERM_BYTE}
              : {1'b0, cmd_addr[6:0], READ_PAD, TERM_BYTE};
            is_reset_reg <= cmd_write && page_reg && {1'b1, cmd_addr[6:0]} == WADDR_GLOB_LO
              && cmd_data == CMD_SWRESET;
            cnt_reg <= 2'd0;
            state_reg <= IMC_SEND;
          end
        end
        IMC_SEND: begin
          frame_reg <= {frame_reg[15:0], 8'h00};
          cnt_reg <= cnt_reg + 2'd1;
          if (cnt_reg == 2'd2) begin
            cnt_reg <= 2'd0;
            if (!write_reg) begin
              state_reg <= IMC_WAIT;
            end else if (is_reset_reg) begin
              wait_reg <= RESET_WAIT;
              state_reg <= IMC_HOLD;
            end else begin
              state_reg <= IMC_IDLE;
            end
          end
        end
        IMC_WAIT: begin
          if (link.d2h_valid) begin
            cnt_reg <= cnt_reg + 2'd1;
            if (cnt_reg == 2'd3) begin
              state_reg <= IMC_IDLE;
            end
          end
        end
        IMC_HOLD: begin
          wait_reg <= wait_reg - 32'h00000001;
          if (wait_reg <= 32'h00000001) begin
            state_reg <= IMC_IDLE;
          end
        end
        default: begin
          state_reg <= IMC_IDLE;
        end
      endcase
    end
  end

  // host copy of the page, needed to recognise the reset command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page_reg <= PAGE_RESET;
    end else if (state_reg == IMC_HOLD) begin
      page_reg <= PAGE_RESET;
    end else if (state_reg == IMC_IDLE && cmd_valid && cmd_write
                 && {1'b1, cmd_addr[6:0]} == ADDR_PAGE) begin
      page_reg <= cmd_data[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.h2d_valid <= 1'b0;
      link.h2d_byte <= 8'h00;
    end else begin
      link.h2d_valid <= state_reg == IMC_SEND;
      link.h2d_byte <= (state_reg == IMC_SEND) ? frame_reg[23:16] : 8'h00;
    end
  end

  // reply collection, upper byte first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_sh_reg <= 24'h000000;
      rsp_valid <= 1'b0;
      rsp_addr <= 8'h00;
      rsp_word <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      if (state_reg == IMC_WAIT && link.d2h_valid) begin
        rsp_sh_reg <= {rsp_sh_reg[15:0], link.d2h_byte};
        if (cnt_reg == 2'd3) begin
          rsp_valid <= link.d2h_byte == TERM_BYTE;
          rsp_addr <= rsp_sh_reg[23:16];
          rsp_word <= rsp_sh_reg[15:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### core/imc_op_timer.sv
`timescale 1ns/100ps
`default_nettype none
module imc_op_timer
  import imc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [15:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      cnt_reg <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start && !busy) begin
      cnt_reg <= OP_CYCLES;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy && cnt_reg == 16'h0001) begin
      cnt_reg <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b1;
    end else begin
      cnt_reg <= busy ? cnt_reg - 16'h0001 : cnt_reg;
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### include/imc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface imc_link_if;
  logic h2d_valid;
  logic [7:0] h2d_byte;
  logic d2h_valid;
  logic [7:0] d2h_byte;
  modport dev (input h2d_valid, input h2d_byte, output d2h_valid, output d2h_byte);
  modport host (output h2d_valid, output h2d_byte, input d2h_valid, input d2h_byte);
endinterface
`default_nettype wire

// ### include/imc_pkg.sv
package imc_pkg;
  // link framing
  localparam logic [7:0] TERM_BYTE = 8'h0d;
  localparam logic [7:0] READ_PAD = 8'h00;
  localparam logic [7:0] ADDR_PAGE = 8'hfe;
  localparam int WR_FLAG_BIT = 7;
  localparam logic PAGE_RESET = 1'b0;
  // read addresses, 16-bit registers
  localparam logic [6:0] REG_MISC = 7'h02;
  localparam logic [6:0] REG_DIAG = 7'h04;
  localparam logic [6:0] REG_FILT = 7'h06;
  localparam logic [6:0] REG_GLOB = 7'h0a;
  // write byte addresses (top bit set)
  localparam logic [7:0] WADDR_MISC_HI = 8'h83;
  localparam logic [7:0] WADDR_FILT_LO = 8'h86;
  localparam logic [7:0] WADDR_GLOB_LO = 8'h8a;
  // command data values
  localparam logic [7:0] CMD_SELFTEST = 8'h04;
  localparam logic [7:0] CMD_FLASHTEST = 8'h08;
  localparam logic [7:0] CMD_SWRESET = 8'h80;
  localparam logic [7:0] CMD_BACKUP = 8'h08;
  localparam logic [7:0] CMD_INITBACKUP = 8'h10;
  localparam logic [7:0] CMD_AVG_32_TAPS = 8'h05;
  // field positions
  localparam int MISC_SELFTEST_BIT = 10;
  localparam int MISC_FLASHTEST_BIT = 11;
  localparam int GLOB_BACKUP_BIT = 3;
  localparam int GLOB_INITBACKUP_BIT = 4;
  localparam int FILT_BUSY_BIT = 5;
  localparam int FILT_SEL_W = 5;
  localparam int DIAG_ST_LSB = 11;
  localparam int DIAG_FLASH_BIT = 2;
  localparam int DIAG_SAVE_BIT = 0;
  localparam logic [FILT_SEL_W-1:0] FILT_SEL_RESET = 5'h00;
  // operation slots
  localparam int OP_SELFTEST = 0;
  localparam int OP_FLASHTEST = 1;
  localparam int OP_BACKUP = 2;
  localparam int OP_INITBACKUP = 3;
  localparam int OP_FILTER = 4;
  localparam int NUM_OPS = 5;
  // timing
  localparam logic [15:0] OP_CYCLES = 16'h0040;
  localparam int CLK_MHZ = 100;
  localparam int RESET_WAIT_MS = 800;
  localparam int RESET_WAIT_CYC = RESET_WAIT_MS * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {
    IMC_IDLE = 2'b00,
    IMC_SEND = 2'b01,
    IMC_WAIT = 2'b11,
    IMC_HOLD = 2'b10
  } imc_host_state_t;
endpackage

// ### sim/imc_link_props.sv
`timescale 1ns/100ps
`default_nettype none
module imc_link_props
  import imc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic h2d_valid,
  input wire logic [7:0] h2d_byte,
  input wire logic d2h_valid,
  input wire logic [7:0] d2h_byte
);
  logic [1:0] idx_reg;
  logic [7:0] b0_reg;
  logic [7:0] b1_reg;
  logic rd_end;
  logic wr_end;
  // byte position inside the current frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_reg <= 2'h0;
    end else if (h2d_valid) begin
      idx_reg <= (idx_reg == 2'h2) ? 2'h0 : idx_reg + 2'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      b0_reg <= 8'h00;
      b1_reg <= 8'h00;
    end else if (h2d_valid && idx_reg == 2'h0) begin
      b0_reg <= h2d_byte;
    end else if (h2d_valid && idx_reg == 2'h1) begin
      b1_reg <= h2d_byte;
    end
  end
  assign rd_end = h2d_valid && idx_reg == 2'h2 && h2d_byte == TERM_BYTE && !b0_reg[7]
    && b1_reg == READ_PAD;
  assign wr_end = h2d_valid && idx_reg == 2'h2 && b0_reg[7];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reply_len_a: assert property (rd_end |-> ##2 d2h_valid [*4] ##1 !d2h_valid)
    else $error("read reply is not four bytes");
  echo_addr_a: assert property (rd_end |-> ##2 d2h_byte == $past(b0_reg, 2))
    else $error("reply does not echo the address");
  reply_term_a: assert property (rd_end |-> ##5 d2h_byte == TERM_BYTE)
    else $error("reply does not end with terminator");
  // a read right behind the write may answer from the fifth cycle on
  write_silent_a: assert property (wr_end && !d2h_valid |-> ##1 !d2h_valid [*4])
    else $error("write frame answered");
  reply_cause_a: assert property ($rose(d2h_valid) |-> $past(rd_end, 2))
    else $error("reply without read frame");
  frame_term_a: assert property (h2d_valid && idx_reg == 2'h2 |-> h2d_byte == TERM_BYTE)
    else $error("frame without terminator");
  read_pad_a: assert property (h2d_valid && idx_reg == 2'h1 && !b0_reg[7]
    |-> h2d_byte == READ_PAD)
    else $error("read frame pad byte wrong");
  idle_zero_a: assert property (!d2h_valid |-> d2h_byte == 8'h00)
    else $error("reply byte not zero when idle");
  page_data_a: assert property (h2d_valid && idx_reg == 2'h1 && b0_reg == ADDR_PAGE
    |-> h2d_byte[7:1] == 7'h00)
    else $error("page select data out of range");
  cover property (rd_end);
  cover property (wr_end && b0_reg == ADDR_PAGE);
  cover property (wr_end && b0_reg == WADDR_GLOB_LO);
endmodule
`default_nettype wire

// ### sim/imu_maintenance_command_unit_bench.sv
`timescale 1ns/100ps
`default_nettype none
module imu_maintenance_command_unit_bench
  import imc_pkg::*;
;
  logic clk, rst_n, cmd_valid, cmd_write, cmd_ready, rsp_valid, reset_wait;
  logic [7:0] cmd_addr, cmd_data, rsp_addr;
  logic [15:0] rsp_word, w;
  logic [3:0] selftest_fail_bits;
  logic flash_fail, save_fail, sw_reset, filter_apply;
  logic [FILT_SEL_W-1:0] filter_sel;
  logic [NUM_OPS-1:0] op_busy;
  int errors, samples_checked, cycles, n, applies;
  logic [7:0] op_wa [5] = '{WADDR_MISC_HI, WADDR_MISC_HI, WADDR_GLOB_LO, WADDR_GLOB_LO,
    WADDR_FILT_LO};
  logic [7:0] op_wd [5] = '{CMD_SELFTEST, CMD_FLASHTEST, CMD_BACKUP, CMD_INITBACKUP,
    CMD_AVG_32_TAPS};
  logic [7:0] op_ra [5] = '{8'h02, 8'h02, 8'h0a, 8'h0a, 8'h06};
  int op_bit [5] = '{MISC_SELFTEST_BIT, MISC_FLASHTEST_BIT, GLOB_BACKUP_BIT,
    GLOB_INITBACKUP_BIT, FILT_BUSY_BIT};
  imc_link_if link();
  imc_device i_imc_device(.clk(clk), .rst_n(rst_n), .link(link),
    .selftest_fail_bits(selftest_fail_bits), .flash_fail(flash_fail), .save_fail(save_fail),
    .sw_reset(sw_reset), .filter_sel(filter_sel), .filter_apply(filter_apply),
    .op_busy(op_busy));
  imc_host #(.RESET_WAIT(20)) i_imc_host(.clk(clk), .rst_n(rst_n), .link(link),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_addr(rsp_addr), .rsp_word(rsp_word),
    .reset_wait(reset_wait));
  imc_link_props i_imc_link_props(.clk(clk), .rst_n(rst_n), .h2d_valid(link.h2d_valid),
    .h2d_byte(link.h2d_byte), .d2h_valid(link.d2h_valid), .d2h_byte(link.d2h_byte));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic results();
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    applies += (filter_apply === 1'b1);
    if (cycles == 6000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic req(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_data <= d;
    do @(negedge clk); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    req(1'b0, a, READ_PAD);
    do @(negedge clk); while (rsp_valid !== 1'b1);
    chk("rsp_addr", {8'h00, rsp_addr}, {8'h00, a});
    v = rsp_word;
  endtask
  task automatic run_op(input int i);
    logic [15:0] v;
    int k;
    req(1'b1, ADDR_PAGE, 8'h01);
    req(1'b1, op_wa[i], op_wd[i]);
    rd(op_ra[i], v);
    chk("busy set", 16'(v[op_bit[i]]), 16'h0001);
    k = 0;
    while (v[op_bit[i]] !== 1'b0 && k < 20) begin
      rd(op_ra[i], v);
      k++;
    end
    chk("busy clear", 16'(v[op_bit[i]]), 16'h0000);
  endtask
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 8'h00;
    cmd_data = 8'h00;
    selftest_fail_bits = 4'ha;
    flash_fail = 1'b1;
    save_fail = 1'b1;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    applies = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h04, w);
    chk("diag reset", w, 16'h0000);
    req(1'b1, WADDR_MISC_HI, CMD_SELFTEST);
    rd(8'h02, w);
    chk("page0 command", 16'(op_busy), 16'h0000);
    for (int i = 0; i < 5; i++) begin
      run_op(i);
    end
    chk("filter sel", 16'(filter_sel), 16'h0005);
    chk("filter apply", 16'(applies), 16'h0001);
    req(1'b1, ADDR_PAGE, 8'h00);
    rd(8'h04, w);
    chk("diag fails", w, 16'h5005);
    req(1'b1, ADDR_PAGE, 8'h01);
    req(1'b1, WADDR_GLOB_LO, CMD_SWRESET);
    n = 0;
    while (sw_reset !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk("sw_reset", 16'(sw_reset), 16'h0001);
    n = 0;
    while (reset_wait === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("reset hold", 16'(n > 18), 16'h0001);
    chk("filter after reset", 16'(filter_sel), 16'h0000);
    rd(8'h04, w);
    chk("diag after reset", w, 16'h0000);
    @(posedge clk);
    selftest_fail_bits <= 4'h0;
    run_op(0);
    req(1'b1, ADDR_PAGE, 8'h00);
    rd(8'h04, w);
    chk("selftest pass", w, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
